// ===== adc_step_pkg.sv
// shared constants and carrier types for the converter post-processor
package adc_step_pkg;
    localparam int RESULT_W        = 24;
    localparam int STEP_TH_W       = 10;
    localparam int ACC_W           = 32;
    localparam int CNT_W           = 16;
    localparam int BASE_CLOCKS     = 256;
    localparam int BASE_CLOCKS_W   = 10;
    localparam int HISTORY_DEPTH   = 3;
    localparam int GAIN_W          = 16;
    localparam int GAIN_FRAC       = 15;
    localparam int DIAG_OFF        = 0;
    // field positions
    localparam int STAT_NEW_BIT    = 0;
    localparam int STAT_STEP_BIT   = 1;
    localparam int STAT_REFERR_BIT = 3;
    localparam int CTL_FAST_EN_BIT = 7;
    localparam int PRO_CMP_LO      = 2;
    localparam int PRO_ACC_LO      = 4;
    localparam int CFG_BIAS_LO     = 8;
    localparam int CFG_BOOST_BIT   = 13;
    localparam logic [1:0] PERIOD_DEFAULT = 2'h0;
    localparam logic [2:0] BIAS_NONE      = 3'h0;
    localparam logic [2:0] BIAS_ANALOG_INPUT_SEVEN      = 3'h1;
    localparam logic [2:0] BIAS_ANALOG_INPUT_ELEVEN     = 3'h2;
    localparam logic [1:0] DIAG_POS       = 2'h1;
    localparam logic [1:0] DIAG_BOTH      = 2'h3;
    localparam logic [1:0] ACC_ADD        = 2'h1;
    localparam logic [1:0] ACC_SUB        = 2'h2;
    localparam logic [1:0] CMP_ABS        = 2'h1;
    localparam logic [1:0] CMP_CNT_ABOVE  = 2'h2;
    localparam logic [1:0] CMP_CNT_BELOW  = 2'h3;
    typedef enum logic [1:0] {REF_INTERNAL, REF_EXT1, REF_EXT2, REF_AVDD}
        ref_sel_t;
    typedef struct packed {
        logic       fast_enable;
        logic       step_enable;
        logic       step_vs_main;
        logic [1:0] period_sel;
    } detect_ctl_t;
endpackage

// ===== adc_step_detect_postproc.sv
// fast filter, step detector, result comparator and accumulator
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reference fault flag for open or low first external reference
// - second external reference never flags fault
// - fast filter runs beside main filter
// - fast results go to own register
// - period field selects 256 to 1024 clocks
// - output is average over the period
// - step if differs from any of three previous outputs
// - alternatively compare with latest main output
// - step sets status bit one, interrupt
// - status bit zero marks new output
// - step threshold is ten bits wide
// - history step flag needs three prior outputs
// - reset default period is the shortest
// - dma interrupt after preset result count
// - gain correction applied before storing
// - comparator interrupt on absolute value above
// - count results past threshold, interrupt at limit
// - accumulator adds or subtracts each result
// - accumulator interrupt above its threshold
// - diagnostic current field decode
// - bias voltage on at most one pin
// - boost bit raises bias current
// - detect control bit four enables fast filter
module adc_step_detect_postproc (
    // clock and reset
    input  wire  logic                                clk,
    input  wire  logic                                reset,
    input  wire  logic                                clk_en,
    // modulator samples and main filter results
    input  wire  logic signed [adc_step_pkg::RESULT_W-1:0] mod_sample,
    input  wire  logic                                mod_valid,
    input  wire  logic signed [adc_step_pkg::RESULT_W-1:0] main_result,
    input  wire  logic                                main_valid,
    // reference detector pins
    input  wire  logic                                ref_open_pin,
    input  wire  logic                                ref_low_pin,
    input  wire  adc_step_pkg::ref_sel_t              ref_select,
    // configuration
    input  wire  adc_step_pkg::detect_ctl_t           detect_ctl,
    input  wire  logic [adc_step_pkg::STEP_TH_W-1:0]  step_threshold,
    input  wire  logic signed [adc_step_pkg::GAIN_W-1:0] gain_corr,
    input  wire  logic [5:0]                          postproc_control,
    input  wire  logic [adc_step_pkg::RESULT_W-1:0]   result_compare_threshold,
    input  wire  logic [adc_step_pkg::CNT_W-1:0]      counter_limit_value,
    input  wire  logic signed [adc_step_pkg::ACC_W-1:0] accumulator_threshold,
    input  wire  logic [adc_step_pkg::CNT_W-1:0]      dma_result_count,
    input  wire  logic                                dma_enable,
    input  wire  logic [1:0]                          diag_current_sel,
    input  wire  logic [13:0]                         converter_config,
    input  wire  logic                                status_clear,
    // results and status
    output logic signed [adc_step_pkg::RESULT_W-1:0]  fast_filter_result,
    output logic [3:0]                                detect_status_reg,
    output logic [adc_step_pkg::CNT_W-1:0]            threshold_event_counter,
    output logic signed [adc_step_pkg::ACC_W-1:0]     result_accumulator,
    // interrupts
    output logic                                      step_irq,
    output logic                                      compare_irq,
    output logic                                      count_irq,
    output logic                                      acc_irq,
    output logic                                      dma_irq,
    // analog switch controls
    output logic                                      diag_pos_en,
    output logic                                      diag_neg_en,
    output logic                                      bias_on_analog_input_seven,
    output logic                                      bias_on_analog_input_eleven,
    output logic                                      bias_boost
);
    localparam int SUM_W = adc_step_pkg::RESULT_W + 10;
    localparam int PROD_W = adc_step_pkg::RESULT_W + adc_step_pkg::GAIN_W;

    function automatic logic [SUM_W-1:0] abs_diff(
        input logic signed [adc_step_pkg::RESULT_W-1:0] a,
        input logic signed [adc_step_pkg::RESULT_W-1:0] b);
        logic signed [SUM_W-1:0] d;
        d = SUM_W'(a) - SUM_W'(b);
        abs_diff = d[SUM_W-1] ? SUM_W'(-d) : d;
    endfunction

    // pin-side reference detector inputs are asynchronous
    logic [1:0] open_sync;
    logic [1:0] low_sync;
    always_ff @(posedge clk) begin
        if (reset) begin
            open_sync <= 2'h0;
            low_sync  <= 2'h0;
        end else if (clk_en) begin
            open_sync <= {open_sync[0], ref_open_pin};
            low_sync  <= {low_sync[0], ref_low_pin};
        end
    end

    // fast averaging filter
    logic [adc_step_pkg::BASE_CLOCKS_W+1:0] clk_count;
    logic [adc_step_pkg::BASE_CLOCKS_W+1:0] period_len;
    logic signed [SUM_W-1:0]               sum;
    logic signed [SUM_W-1:0]               next_sum;
    logic                                  period_end;
    logic signed [adc_step_pkg::RESULT_W-1:0] avg;
    logic signed [PROD_W-1:0]              prod;
    logic signed [adc_step_pkg::RESULT_W-1:0] corrected;
    logic                                  fast_run;

    assign fast_run = detect_ctl.fast_enable;
    // one to four base windows
    assign period_len = (adc_step_pkg::BASE_CLOCKS_W+2)'(
        adc_step_pkg::BASE_CLOCKS * (int'(detect_ctl.period_sel) + 1));
    assign period_end = fast_run && mod_valid
        && (clk_count == period_len - 1'b1);
    assign next_sum = sum + SUM_W'(mod_sample);
    // divide by sample count: shift for powers of two, else scale
    always_comb begin
        case (detect_ctl.period_sel)
            2'h0: avg = adc_step_pkg::RESULT_W'(next_sum >>> 8);
            2'h1: avg = adc_step_pkg::RESULT_W'(next_sum >>> 9);
            2'h3: avg = adc_step_pkg::RESULT_W'(next_sum >>> 10);
            default: avg = adc_step_pkg::RESULT_W'(
                (next_sum / 3) >>> 8);
        endcase
    end
    assign prod = PROD_W'(avg) * PROD_W'(gain_corr);
    assign corrected = adc_step_pkg::RESULT_W'(
        prod >>> adc_step_pkg::GAIN_FRAC);

    // runs independently of the main filter path
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_count <= '0;
            sum       <= '0;
        end else if (clk_en) begin
            if (!fast_run) begin
                clk_count <= '0;
                sum       <= '0;
            end else if (mod_valid) begin
                if (period_end) begin
                    clk_count <= '0;
                    sum       <= '0;
                end else begin
                    clk_count <= clk_count + 1'b1;
                    sum       <= next_sum;
                end
            end
        end
    end

    // output register and history of three previous outputs
    logic signed [adc_step_pkg::RESULT_W-1:0] hist [adc_step_pkg::HISTORY_DEPTH];
    logic [1:0]                              hist_fill;
    logic signed [adc_step_pkg::RESULT_W-1:0] last_main;
    logic [adc_step_pkg::HISTORY_DEPTH-1:0]  over;
    logic                                    step_hit;

    genvar g;
    generate
        for (g = 0; g < adc_step_pkg::HISTORY_DEPTH; g++) begin : g_cmp
            assign over[g] = (hist_fill > g) && (abs_diff(corrected, hist[g])
                > SUM_W'(step_threshold));
        end
    endgenerate

    // history mode needs full history, so earliest flag is at the fourth output
    assign step_hit = detect_ctl.step_enable && (detect_ctl.step_vs_main
        ? (abs_diff(corrected, last_main) > SUM_W'(step_threshold))
        : ((hist_fill == 2'h3) && (|over)));

    always_ff @(posedge clk) begin
        if (reset) begin
            fast_filter_result <= '0;
            hist_fill <= 2'h0;
            last_main <= '0;
            for (int i = 0; i < adc_step_pkg::HISTORY_DEPTH; i++)
                hist[i] <= '0;
        end else if (clk_en) begin
            if (main_valid)
                last_main <= main_result;
            if (!fast_run)
                hist_fill <= 2'h0;
            else if (period_end) begin
                fast_filter_result <= corrected;
                hist[0] <= corrected;
                for (int i = 1; i < adc_step_pkg::HISTORY_DEPTH; i++)
                    hist[i] <= hist[i-1];
                if (hist_fill != 2'h3)
                    hist_fill <= hist_fill + 1'b1;
            end
        end
    end

    // status: set beats clear
    logic ref_fault;
    assign ref_fault = (ref_select == adc_step_pkg::REF_EXT1)
        && (open_sync[1] || low_sync[1]);
    always_ff @(posedge clk) begin
        if (reset) begin
            detect_status_reg <= 4'h0;
            step_irq          <= 1'b0;
        end else if (clk_en) begin
            detect_status_reg[adc_step_pkg::STAT_NEW_BIT] <=
                period_end || (detect_status_reg[0] && !status_clear);
            detect_status_reg[adc_step_pkg::STAT_STEP_BIT] <=
                (period_end && step_hit)
                || (detect_status_reg[1] && !status_clear);
            detect_status_reg[2] <= 1'b0;
            detect_status_reg[adc_step_pkg::STAT_REFERR_BIT] <=
                ref_fault || (detect_status_reg[3] && !status_clear);
            step_irq <= period_end && step_hit;
        end
    end

    // dma block counter
    logic [adc_step_pkg::CNT_W-1:0] dma_count;
    always_ff @(posedge clk) begin
        if (reset) begin
            dma_count <= '0;
            dma_irq   <= 1'b0;
        end else if (clk_en) begin
            dma_irq <= 1'b0;
            if (dma_enable && period_end) begin
                if (dma_count + 1'b1 >= dma_result_count) begin
                    dma_count <= '0;
                    dma_irq   <= 1'b1;
                end else
                    dma_count <= dma_count + 1'b1;
            end
        end
    end

    // comparator, threshold counter and accumulator on main results
    logic [1:0] cmp_mode;
    logic [1:0] acc_mode;
    logic [adc_step_pkg::RESULT_W-1:0] mag;
    logic above;
    logic signed [adc_step_pkg::ACC_W-1:0] next_acc;
    assign cmp_mode = postproc_control[adc_step_pkg::PRO_CMP_LO +: 2];
    assign acc_mode = postproc_control[adc_step_pkg::PRO_ACC_LO +: 2];
    assign mag = main_result[adc_step_pkg::RESULT_W-1]
        ? adc_step_pkg::RESULT_W'(-main_result) : main_result;
    assign above = mag > result_compare_threshold;
    always_comb begin
        case (acc_mode)
            adc_step_pkg::ACC_ADD:
                next_acc = result_accumulator
                    + adc_step_pkg::ACC_W'(main_result);
            adc_step_pkg::ACC_SUB:
                next_acc = result_accumulator
                    - adc_step_pkg::ACC_W'(main_result);
            default: next_acc = result_accumulator;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            threshold_event_counter <= '0;
            compare_irq <= 1'b0;
            count_irq   <= 1'b0;
        end else if (clk_en) begin
            compare_irq <= main_valid && cmp_mode == adc_step_pkg::CMP_ABS
                && above;
            count_irq <= 1'b0;
            if (main_valid && (((cmp_mode == adc_step_pkg::CMP_CNT_ABOVE)
                && above) || ((cmp_mode == adc_step_pkg::CMP_CNT_BELOW)
                && !above))) begin
                if (threshold_event_counter + 1'b1
                    == counter_limit_value) begin
                    threshold_event_counter <= '0;
                    count_irq <= 1'b1;
                end else
                    threshold_event_counter <=
                        threshold_event_counter + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            result_accumulator <= '0;
            acc_irq <= 1'b0;
        end else if (clk_en) begin
            acc_irq <= 1'b0;
            if (main_valid && acc_mode != 2'h0) begin
                result_accumulator <= next_acc;
                acc_irq <= next_acc > accumulator_threshold;
            end
        end
    end

    // analog switch decodes
    logic [2:0] bias_sel;
    assign bias_sel = converter_config[adc_step_pkg::CFG_BIAS_LO +: 3];
    always_ff @(posedge clk) begin
        if (reset) begin
            diag_pos_en   <= 1'b0;
            diag_neg_en   <= 1'b0;
            bias_on_analog_input_seven  <= 1'b0;
            bias_on_analog_input_eleven <= 1'b0;
            bias_boost    <= 1'b0;
        end else if (clk_en) begin
            diag_pos_en <= diag_current_sel == adc_step_pkg::DIAG_POS
                || diag_current_sel == adc_step_pkg::DIAG_BOTH;
            diag_neg_en <= diag_current_sel == adc_step_pkg::DIAG_BOTH;
            bias_on_analog_input_seven  <= bias_sel == adc_step_pkg::BIAS_ANALOG_INPUT_SEVEN;
            bias_on_analog_input_eleven <= bias_sel == adc_step_pkg::BIAS_ANALOG_INPUT_ELEVEN;
            bias_boost <= converter_config[adc_step_pkg::CFG_BOOST_BIT];
        end
    end

    step_window_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && period_end && step_hit) |=> step_irq && detect_status_reg[1])
        else $error("step not flagged");
    new_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && period_end) |=> detect_status_reg[0]
        && fast_filter_result == $past(corrected))
        else $error("new result not flagged");
    ref2_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && ref_select == adc_step_pkg::REF_EXT2 && !detect_status_reg[3]
        && !status_clear) |=> !detect_status_reg[3])
        else $error("ext ref2 fault raised");
    step_history_a: assert property (@(posedge clk) disable iff (reset)
        (step_irq && !$past(detect_ctl.step_vs_main)) |-> $past(hist_fill) == 2'h3)
        else $error("step before three outputs");
    period_len_a: assert property (@(posedge clk) disable iff (reset)
        fast_run |-> clk_count < period_len)
        else $error("period length wrong");
    diag_decode_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && diag_current_sel == 2'h0) |=> !diag_pos_en && !diag_neg_en)
        else $error("diag currents not off");
    bias_single_a: assert property (@(posedge clk) disable iff (reset)
        !(bias_on_analog_input_seven && bias_on_analog_input_eleven))
        else $error("bias on two pins");
    acc_step_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && main_valid && acc_mode == adc_step_pkg::ACC_ADD)
        |=> result_accumulator == $past(result_accumulator)
        + adc_step_pkg::ACC_W'($past(main_result)))
        else $error("accumulator add wrong");
endmodule
`default_nettype wire

// ===== adc_source_model.sv
// behavioural source of modulator samples and main filter results
`timescale 1ns/1ps
`default_nettype none
module adc_source_model (
    // clock
    input  wire logic               clk,
    // toward the post-processor
    output var  logic signed [23:0] mod_sample,
    output var  logic               mod_valid,
    output var  logic signed [23:0] main_result,
    output var  logic               main_valid
);
    initial begin
        mod_valid = 1'b0;
        main_valid = 1'b0;
        mod_sample = 24'h5A5A5A;
        main_result = 24'hA5A5A5;
    end
    // data shows the inverse once a strobe drops, never a stale copy
    task automatic burst(input int n, input logic signed [23:0] v,
                         input bit slow);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1 mod_valid = 1'b1;
            mod_sample = v;
            if (slow) begin
                @(posedge clk);
                #1 mod_valid = 1'b0;
                mod_sample = ~v;
            end
        end
        @(posedge clk);
        #1 mod_valid = 1'b0;
        mod_sample = ~v;
    endtask
    task automatic main_out(input logic signed [23:0] v);
        @(posedge clk);
        #1 main_valid = 1'b1;
        main_result = v;
        @(posedge clk);
        #1 main_valid = 1'b0;
        main_result = ~v;
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the converter post-processor
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {logic signed [23:0] r; logic st;} fast_exp_t;
    typedef struct packed {
        logic cm, cmp, cnti, acci; logic [15:0] cnt; logic [31:0] acc;
    } main_exp_t;
    logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic signed [23:0] mod_sample, main_result, fast_filter_result;
    logic mod_valid, main_valid, dma_enable = 1'b1, status_clear = 1'b1;
    logic ref_open_pin = 1'b0, ref_low_pin = 1'b0;
    adc_step_pkg::ref_sel_t ref_select = adc_step_pkg::REF_INTERNAL;
    adc_step_pkg::detect_ctl_t detect_ctl = '0;
    logic [9:0] step_threshold = 10'h0C8;
    logic signed [15:0] gain_corr = 16'h4000;
    logic [5:0] postproc_control = 6'h00;
    logic [23:0] result_compare_threshold = 24'h0003E8;
    logic [15:0] counter_limit_value = 16'h0003, dma_result_count = 16'h0001;
    logic signed [31:0] accumulator_threshold = 32'h00002710, acc = '0;
    logic [1:0] diag_current_sel = 2'h0;
    logic [13:0] converter_config = 14'h0000;
    logic [3:0] detect_status_reg;
    logic [15:0] threshold_event_counter, cnt = '0;
    logic signed [31:0] result_accumulator;
    logic step_irq, compare_irq, count_irq, acc_irq, dma_irq, mv_d = 1'b0;
    logic diag_pos_en, diag_neg_en, bias_on_analog_input_seven, bias_on_analog_input_eleven, bias_boost;
    logic signed [23:0] h [3];
    logic signed [23:0] last_main = '0;
    fast_exp_t qf[$];
    main_exp_t qm[$];
    int bad_count = 0, cmp_count = 0, hn = 0;

    adc_step_detect_postproc DUT (
        .clk, .reset, .clk_en, .mod_sample, .mod_valid, .main_result,
        .main_valid, .ref_open_pin, .ref_low_pin, .ref_select, .detect_ctl,
        .step_threshold, .gain_corr, .postproc_control,
        .result_compare_threshold, .counter_limit_value,
        .accumulator_threshold, .dma_result_count, .dma_enable,
        .diag_current_sel, .converter_config, .status_clear,
        .fast_filter_result, .detect_status_reg, .threshold_event_counter,
        .result_accumulator, .step_irq, .compare_irq, .count_irq, .acc_irq,
        .dma_irq, .diag_pos_en, .diag_neg_en, .bias_on_analog_input_seven, .bias_on_analog_input_eleven,
        .bias_boost
    );
    adc_source_model src (
        .clk, .mod_sample, .mod_valid, .main_result, .main_valid
    );

    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic int mag(input int x);
        return x < 0 ? -x : x;
    endfunction
    // even levels keep the half gain exact; steps are multiples of 500 apart, up to 2000
    function automatic logic signed [23:0] lvl();
        return 24'(int'($urandom % 5) * 1000 - 2000);
    endfunction
    // restarting the fast path also empties its history
    task automatic fast_on(input logic [1:0] p);
        detect_ctl.fast_enable = 1'b0;
        repeat (2) @(posedge clk);
        #1 detect_ctl.period_sel = p;
        detect_ctl.fast_enable = 1'b1;
        hn = 0;
    endtask
    task automatic period(input logic signed [23:0] v, input bit slow);
        fast_exp_t f;
        logic signed [23:0] c;
        c = v / 2;
        f.r = c;
        f.st = 1'b0;
        if (detect_ctl.step_enable && hn >= 3) begin
            if (detect_ctl.step_vs_main)
                f.st = mag(c - last_main) > int'(step_threshold);
            else
                for (int j = 0; j < 3; j++)
                    f.st |= mag(c - h[j]) > int'(step_threshold);
        end
        h[2] = h[1];
        h[1] = h[0];
        h[0] = c;
        hn++;
        qf.push_back(f);
        src.burst(256 * (detect_ctl.period_sel + 1), v, slow);
    endtask
    task automatic main(input logic signed [23:0] v);
        main_exp_t m;
        logic [1:0] cm, am;
        cm = postproc_control[3:2];
        am = postproc_control[5:4];
        m = '0;
        m.cm = cm[1];
        m.cmp = cm == adc_step_pkg::CMP_ABS &&
                mag(v) > int'(result_compare_threshold);
        if (cm[1] && (cm[0] ? mag(v) < int'(result_compare_threshold)
                            : mag(v) > int'(result_compare_threshold))) begin
            m.cnti = cnt + 16'h0001 == counter_limit_value;
            cnt = m.cnti ? 16'h0000 : cnt + 16'h0001;
        end
        if (am == adc_step_pkg::ACC_ADD)
            acc = acc + v;
        else if (am == adc_step_pkg::ACC_SUB)
            acc = acc - v;
        m.acci = am != 2'h0 && acc > accumulator_threshold;
        m.cnt = cnt;
        m.acc = acc;
        last_main = v;
        qm.push_back(m);
        src.main_out(v);
    endtask

    // outputs are settled by the falling edge
    always @(negedge clk) begin
        fast_exp_t f;
        main_exp_t m;
        if (dma_irq === 1'b1) begin
            chk("fast_pending", 1, qf.size() > 0);
            f = qf.pop_front();
            chk("fast_result", f.r, fast_filter_result);
            chk("new_flag", 1, detect_status_reg[0]);
            chk("step_irq", f.st, step_irq);
            chk("step_flag", f.st, detect_status_reg[1]);
        end
        if (mv_d) begin
            m = qm.pop_front();
            if (m.cm) begin
                chk("count_irq", m.cnti, count_irq);
                chk("counter", m.cnt, threshold_event_counter);
            end else
                chk("compare_irq", m.cmp, compare_irq);
            chk("acc_irq", m.acci, acc_irq);
            chk("accumulator", m.acc, result_accumulator);
        end
        mv_d = main_valid;
    end

    initial begin
        repeat (12000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(96));
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        step_threshold = 10'(100 + $urandom % 300);
        result_compare_threshold = 24'(1000 + $urandom % 1000);
        counter_limit_value = 16'(2 + $urandom % 3);
        accumulator_threshold = 32'(5000 + $urandom % 10000);
        @(posedge clk);
        #1 chk("reset_status", 0, detect_status_reg);
        chk("reset_acc", 0, result_accumulator);
        for (int p = 0; p < 4; p++) begin
            fast_on(2'(p));
            period(lvl(), p == 1);
        end
        detect_ctl.step_enable = 1'b1;
        fast_on(adc_step_pkg::PERIOD_DEFAULT);
        repeat (12) period(lvl(), 1'b0);
        detect_ctl.step_vs_main = 1'b1;
        main(24'sd0);
        repeat (4) period(lvl(), 1'b0);
        detect_ctl = '0;
        postproc_control = {adc_step_pkg::ACC_ADD,
                            adc_step_pkg::CMP_CNT_ABOVE, 2'h0};
        for (int i = 0; i < 12; i++)
            main(i[0] ? 24'sd3000 : 24'sd5);
        postproc_control = {adc_step_pkg::ACC_SUB,
                            adc_step_pkg::CMP_CNT_BELOW, 2'h0};
        for (int i = 0; i < 12; i++)
            main(i[0] ? 24'sd3000 : 24'sd5);
        postproc_control = {2'h0, adc_step_pkg::CMP_ABS, 2'h0};
        for (int i = 0; i < 8; i++)
            main(($urandom % 2 ? 24'sd3000 : 24'sd5) *
                 ($urandom % 2 ? 24'sd1 : -24'sd1));
        status_clear = 1'b0;
        for (int s = 1; s < 5; s++) begin
            ref_select = adc_step_pkg::ref_sel_t'(s == 4 ? 1 : s);
            ref_open_pin = s == 1 || s == 2;
            ref_low_pin = s != 1;
            repeat (6) @(posedge clk);
            #1 chk("ref_fault", s == 1 || s == 4, detect_status_reg[3]);
            ref_open_pin = 1'b0;
            ref_low_pin = 1'b0;
            status_clear = 1'b1;
            repeat (6) @(posedge clk);
            #1 chk("ref_clear", 0, detect_status_reg[3]);
            status_clear = 1'b0;
        end
        for (int i = 0; i < 16; i++) begin
            diag_current_sel = 2'($urandom);
            if (diag_current_sel == 2'h2)
                diag_current_sel = adc_step_pkg::DIAG_BOTH;
            converter_config = {i[3], 2'h0, i[2:0], 8'($urandom)};
            repeat (2) @(posedge clk);
            #1 chk("diag_pos", diag_current_sel != 2'h0, diag_pos_en);
            chk("diag_neg", diag_current_sel == 2'h3, diag_neg_en);
            chk("bias_7", i[2:0] == 3'h1, bias_on_analog_input_seven);
            chk("bias_11", i[2:0] == 3'h2, bias_on_analog_input_eleven);
            chk("boost", i[3], bias_boost);
        end
        repeat (4) @(posedge clk);
        chk("fast_left", 0, qf.size());
        give_verdict();
    end
endmodule
`default_nettype wire
